// ### design/pmrc_top.sv
`timescale 1ns/100ps
// What this block does
// - Regulator modes: main, low-power, power-down, and off with external supply.
// - Bypass pin low keeps regulator enabled; high disables it.
// - Run and Sleep use main regulator normal; over-drive only when software enables.
// - Stop picks main or low-power regulator, normal or under-drive.
// - Power-down only on Standby entry; contents lost.
// - Bypassed regulator refuses over-drive and under-drive.
// - Bypassed: core reset pin resets uncovered core part, never general I/O.
// - Core reset pin low blocks debug under power-on reset.
// - Sleep halts only processor; any peripheral interrupt or event returns Run.
// - Stop halts core clocks, PLL and fast oscillators; contents kept.
// - Any external event line wakes from Stop.
// - Standby powers off regulator, core, PLL, oscillators; backup kept.
// - Standby left on resets, wakeup pin edges or RTC events.
// - Standby unavailable while regulator bypassed.
module pmrc_top
    import pmrc_pkg::*;
#(
    parameter int N_LINES = PMRC_EXT_LINES,
    parameter int N_WKPIN = PMRC_WK_PINS
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                bypass_pin,
    input  wire logic                core_domain_reset_pin,
    input  wire logic                external_reset_pin,
    input  wire logic                independent_watchdog,
    input  wire logic [N_WKPIN-1:0]  wakeup_pin,
    input  wire logic [N_LINES-1:0]  external_event_line,
    input  wire logic                voltage_detector_output,
    input  wire logic [3:0]          rtc_event,
    input  wire logic                usb_wakeup,
    input  wire logic                low_power_timer,
    input  wire logic                periph_irq,
    output logic                     cpu_halt,
    output logic                     core_clk_gate,
    output logic                     pll_en,
    output logic                     internal_fast_oscillator_en,
    output logic                     external_fast_oscillator_en,
    output logic                     main_regulator_en,
    output logic                     low_power_regulator_en,
    output logic                     reg_overdrive,
    output logic                     reg_underdrive,
    output logic                     reg_powerdown,
    output logic                     core_power_en,
    output logic                     retain_contents,
    output logic                     backup_sram_keep,
    output logic                     core_part_reset_n,
    output logic                     debug_por_allowed,
    output logic                     standby_reset_req
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NS = N_LINES + N_WKPIN + 11;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] lvl;
    logic [NS-1:0] edg;

    assign raw_in = {bypass_pin, core_domain_reset_pin, external_reset_pin,
                     independent_watchdog, voltage_detector_output,
                     rtc_event, usb_wakeup, low_power_timer,
                     wakeup_pin, external_event_line};

    pmrc_edge_sync #(.W(NS)) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (clk_en),
        .async_in  (raw_in),
        .level_out (lvl),
        .edge_out  (edg)
    );

    logic [N_LINES-1:0] line_s;
    logic [N_WKPIN-1:0] wkpin_e;
    logic               lptim_s;
    logic               usb_s;
    logic [3:0]         rtc_s;
    logic               pvd_s;
    logic               wdg_s;
    logic               xrst_s;
    logic               crst_s;
    logic               bypass_s;

    assign line_s   = lvl[N_LINES-1:0];
    assign wkpin_e  = edg[N_LINES +: N_WKPIN];
    assign lptim_s  = lvl[N_LINES+N_WKPIN];
    assign usb_s    = lvl[N_LINES+N_WKPIN+1];
    assign rtc_s    = lvl[N_LINES+N_WKPIN+2 +: 4];
    assign pvd_s    = lvl[N_LINES+N_WKPIN+6];
    assign wdg_s    = lvl[N_LINES+N_WKPIN+7];
    assign xrst_s   = lvl[N_LINES+N_WKPIN+8];
    assign crst_s   = lvl[N_LINES+N_WKPIN+9];
    assign bypass_s = lvl[N_LINES+N_WKPIN+10];

    // ************************************************************
    // Registers and state
    // ************************************************************
    typedef enum logic [1:0] {
        PMRC_RUN,
        PMRC_SLEEP,
        PMRC_STOP,
        PMRC_STANDBY
    } pmrc_mode_t;

    pmrc_mode_t  mode_q;
    logic [31:0] ctrl_q;
    logic [31:0] wkcfg_q;
    logic [3:0]  wksrc_q;
    logic        apb_wr;
    logic        ovd_ok;
    logic        udr_ok;
    logic [1:0]  req;
    logic        stop_wake;
    logic        stby_wake;
    logic        sleep_wake;
    logic        stby_ok;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == PMRC_CTRL_OFS) || (a == PMRC_STATUS_OFS) ||
                  (a == PMRC_WKCFG_OFS) || (a == PMRC_WKSRC_OFS);
    endfunction

    assign apb_wr = psel && penable && pwrite && addr_ok(paddr);
    assign req    = ctrl_q[CTRL_REQ_LSB +: 2];

    // A bypassed regulator has no internal scaling to push or pull.
    assign ovd_ok = ctrl_q[CTRL_OVD_BIT] && !bypass_s;
    assign udr_ok = ctrl_q[CTRL_UDR_BIT] && !bypass_s;
    assign stby_ok = !bypass_s;

    assign stop_wake  = (|line_s) || pvd_s || (|rtc_s) || usb_s ||
                        lptim_s;
    assign stby_wake  = !xrst_s || wdg_s || (|wkpin_e) || (|rtc_s);
    assign sleep_wake = periph_irq || stop_wake;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RESET;
            wkcfg_q <= WKCFG_RESET;
        end else if (clk_en) begin
            if (apb_wr && paddr == PMRC_CTRL_OFS) begin
                ctrl_q <= pwdata;
            end else if (mode_q != PMRC_RUN) begin
                // The request is consumed once the mode is entered.
                ctrl_q[CTRL_REQ_LSB +: 2] <= PMRC_REQ_NONE;
            end
            if (apb_wr && paddr == PMRC_WKCFG_OFS) begin
                wkcfg_q <= pwdata;
            end
        end
    end

    // Requests are taken only in Run, so one mode is ever current.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= PMRC_RUN;
        end else if (clk_en) begin
            case (mode_q)
                PMRC_RUN: begin
                    case (req)
                        PMRC_REQ_SLEEP:   mode_q <= PMRC_SLEEP;
                        PMRC_REQ_STOP:    mode_q <= PMRC_STOP;
                        PMRC_REQ_STANDBY: begin
                            if (stby_ok) begin
                                mode_q <= PMRC_STANDBY;
                            end
                        end
                        default:          mode_q <= PMRC_RUN;
                    endcase
                end
                PMRC_SLEEP: begin
                    if (sleep_wake) begin
                        mode_q <= PMRC_RUN;
                    end
                end
                PMRC_STOP: begin
                    if (stop_wake) begin
                        mode_q <= PMRC_RUN;
                    end
                end
                PMRC_STANDBY: begin
                    if (stby_wake) begin
                        mode_q <= PMRC_RUN;
                    end
                end
                default: mode_q <= PMRC_RUN;
            endcase
        end
    end

    // Wake source record: set wins over a software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wksrc_q <= 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (apb_wr && paddr == PMRC_WKSRC_OFS && pwdata[i]) begin
                    wksrc_q[i] <= 1'b0;
                end
            end
            if (mode_q == PMRC_SLEEP && sleep_wake) begin
                wksrc_q[0] <= 1'b1;
            end
            if (mode_q == PMRC_STOP && stop_wake) begin
                wksrc_q[1] <= 1'b1;
            end
            if (mode_q == PMRC_STANDBY && stby_wake) begin
                wksrc_q[2] <= 1'b1;
            end
            if (mode_q == PMRC_RUN && req == PMRC_REQ_STANDBY &&
                !stby_ok) begin
                wksrc_q[3] <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Power outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_halt                    <= 1'b0;
            core_clk_gate               <= 1'b0;
            pll_en                      <= 1'b1;
            internal_fast_oscillator_en <= 1'b1;
            external_fast_oscillator_en <= 1'b1;
            main_regulator_en           <= 1'b1;
            low_power_regulator_en      <= 1'b0;
            reg_overdrive               <= 1'b0;
            reg_underdrive              <= 1'b0;
            reg_powerdown               <= 1'b0;
            core_power_en               <= 1'b1;
            retain_contents             <= 1'b1;
            backup_sram_keep            <= 1'b0;
            core_part_reset_n           <= 1'b0;
            debug_por_allowed           <= 1'b0;
            standby_reset_req           <= 1'b0;
        end else if (clk_en) begin
            cpu_halt      <= (mode_q != PMRC_RUN);
            core_clk_gate <= (mode_q == PMRC_STOP) ||
                             (mode_q == PMRC_STANDBY);
            pll_en        <= (mode_q == PMRC_RUN) ||
                             (mode_q == PMRC_SLEEP);
            internal_fast_oscillator_en <= (mode_q == PMRC_RUN) ||
                                           (mode_q == PMRC_SLEEP);
            external_fast_oscillator_en <= (mode_q == PMRC_RUN) ||
                                           (mode_q == PMRC_SLEEP);
            // Off state: core supply comes from outside.
            main_regulator_en <= !bypass_s && (mode_q != PMRC_STANDBY) &&
                !(mode_q == PMRC_STOP && ctrl_q[CTRL_LPR_BIT]);
            low_power_regulator_en <= !bypass_s && (mode_q == PMRC_STOP) &&
                ctrl_q[CTRL_LPR_BIT];
            reg_overdrive  <= ovd_ok && ((mode_q == PMRC_RUN) ||
                              (mode_q == PMRC_SLEEP));
            reg_underdrive <= udr_ok && (mode_q == PMRC_STOP);
            reg_powerdown  <= (mode_q == PMRC_STANDBY);
            core_power_en  <= (mode_q != PMRC_STANDBY);
            retain_contents <= (mode_q != PMRC_STANDBY);
            backup_sram_keep <= ctrl_q[CTRL_BKSRAM_BIT];
            // The pin resets the core part only while bypassed; otherwise core_part_reset_n is held high, but the pin still gates debug_por_allowed.
            core_part_reset_n <= bypass_s ? crst_s : 1'b1;
            debug_por_allowed <= crst_s;
            standby_reset_req <= (mode_q == PMRC_STANDBY) &&
                                 stby_wake;
        end
    end

    // ************************************************************
    // APB read and response
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok(paddr);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    PMRC_CTRL_OFS:   prdata <= ctrl_q;
                    PMRC_STATUS_OFS: prdata <= {24'h000000, bypass_s,
                        reg_powerdown, reg_underdrive, reg_overdrive,
                        low_power_regulator_en, main_regulator_en,
                        2'(mode_q)};
                    PMRC_WKCFG_OFS:  prdata <= wkcfg_q;
                    PMRC_WKSRC_OFS:  prdata <= {28'h0000000, wksrc_q};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ### design/pmrc_pkg.sv
package pmrc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] PMRC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] PMRC_STATUS_OFS = 12'h004;
    localparam logic [11:0] PMRC_WKCFG_OFS  = 12'h008;
    localparam logic [11:0] PMRC_WKSRC_OFS  = 12'h00C;

    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int CTRL_REQ_LSB   = 0;
    localparam int CTRL_OVD_BIT   = 2;
    localparam int CTRL_LPR_BIT   = 3;
    localparam int CTRL_UDR_BIT   = 4;
    localparam int CTRL_BKSRAM_BIT = 5;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] WKCFG_RESET  = 32'h0000_0000;

    // ************************************************************
    // Wakeup counts
    // ************************************************************
    localparam int PMRC_EXT_LINES = 16;
    localparam int PMRC_WK_PINS   = 6;
    localparam int PMRC_RTC_EVTS  = 4;
    localparam int PMRC_OTH_EVTS  = 3;

    typedef enum logic [1:0] {
        PMRC_REQ_NONE,
        PMRC_REQ_SLEEP,
        PMRC_REQ_STOP,
        PMRC_REQ_STANDBY
    } pmrc_req_t;

    typedef enum logic [2:0] {
        PMRC_REG_MAIN,
        PMRC_REG_LOWPWR,
        PMRC_REG_PWRDN,
        PMRC_REG_OFF
    } pmrc_reg_t;

endpackage

// ### design/pmrc_edge_sync.sv
`timescale 1ns/100ps
module pmrc_edge_sync
    import pmrc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] edge_out
);
    // The first stage is read only by the second stage.
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign edge_out  = sync_q ^ prev_q;
endmodule

// ### dv/pmrc_top_chk.sv
`timescale 1ns/100ps
module pmrc_top_chk
    import pmrc_pkg::*;
#(
    parameter int N_LINES = PMRC_EXT_LINES
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic [11:0]        paddr,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               bypass_pin,
    input wire logic               core_domain_reset_pin,
    input wire logic               periph_irq,
    input wire logic [N_LINES-1:0] external_event_line,
    input wire logic               cpu_halt,
    input wire logic               pll_en,
    input wire logic               external_fast_oscillator_en,
    input wire logic               main_regulator_en,
    input wire logic               low_power_regulator_en,
    input wire logic               reg_overdrive,
    input wire logic               reg_underdrive,
    input wire logic               reg_powerdown,
    input wire logic               core_power_en,
    input wire logic               retain_contents,
    input wire logic               core_part_reset_n,
    input wire logic               debug_por_allowed,
    input wire logic               standby_reset_req
);
    // ************************************************************
    // Mode output relations
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ovd_main: assert property (
        reg_overdrive |-> main_regulator_en && pll_en)
        else $error("overdrive outside main regulator run");
    a_udr_stop: assert property (
        reg_underdrive |-> !pll_en && !reg_powerdown
        && (main_regulator_en || low_power_regulator_en))
        else $error("underdrive outside stop");
    a_pwrdn_off: assert property (
        reg_powerdown |-> !core_power_en
        && !retain_contents && !pll_en && !main_regulator_en)
        else $error("standby left something powered");
    a_stop_keep: assert property (
        !pll_en && !reg_powerdown |-> retain_contents
        && core_power_en && cpu_halt && !external_fast_oscillator_en)
        else $error("stop lost contents or kept clocks");
    // Six cycles cover the two-stage synchroniser plus state and output.
    a_bypass_drive: assert property (
        (bypass_pin)[*6] |-> !reg_overdrive && !reg_underdrive)
        else $error("drive setting while bypassed");
    a_bypass_stby: assert property (
        (bypass_pin)[*6] |-> !reg_powerdown)
        else $error("standby while bypassed");
    a_core_reset: assert property (
        (bypass_pin && !core_domain_reset_pin)[*5] |-> !core_part_reset_n)
        else $error("core part reset not applied");
    a_debug_block: assert property (
        (!core_domain_reset_pin)[*5] |-> !debug_por_allowed)
        else $error("debug allowed under core reset");
    a_sleep_wake: assert property (
        cpu_halt && pll_en && periph_irq |-> ##[1:4] !cpu_halt)
        else $error("sleep not left on interrupt");
    a_stop_wake: assert property (
        !pll_en && !reg_powerdown
        && (|external_event_line) |-> ##[1:8] pll_en)
        else $error("stop not left on event line");
    a_stby_exit: assert property (
        standby_reset_req |=> !reg_powerdown)
        else $error("standby not left after wake request");
    a_apb_refuse: assert property (pready && psel |-> pslverr == (paddr > 12'h00C))
        else $error("error response does not match address");
    c_sleep: cover property (cpu_halt && pll_en);
    c_stop_udr: cover property (reg_underdrive && low_power_regulator_en);
    c_standby: cover property (reg_powerdown);
endmodule

bind pmrc_top pmrc_top_chk #(.N_LINES(N_LINES)) pmrc_top_chk_inst (.*);

// ### dv/pmrc_top_tb_top.sv
`timescale 1ns/100ps
module pmrc_top_tb_top
    import pmrc_pkg::*;
;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        bypass_pin, core_domain_reset_pin, external_reset_pin, er;
    logic        independent_watchdog, voltage_detector_output, usb_wakeup;
    logic        low_power_timer, periph_irq, cpu_halt, core_clk_gate, pll_en;
    logic [5:0]  wakeup_pin;
    logic [15:0] external_event_line;
    logic [3:0]  rtc_event;
    logic        internal_fast_oscillator_en, external_fast_oscillator_en;
    logic        main_regulator_en, low_power_regulator_en, reg_overdrive;
    logic        reg_underdrive, reg_powerdown, core_power_en, retain_contents;
    logic        backup_sram_keep, core_part_reset_n, debug_por_allowed;
    logic        standby_reset_req;
    int          err_count, total_checks;
    int          src [8] = '{0, 15, 16, 17, 20, 21, 22, 8};

    pmrc_top #(.N_LINES(16), .N_WKPIN(6)) pmrc_top_inst (.*);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request stays put until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_for(ref logic s, input logic v);
        int n = 0;
        while (s !== v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (s !== v) begin
            err_count++;
            complete_run();
        end
        repeat (2) @(posedge pclk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_run_regs();
        chk(pll_en, 32'h1);
        chk(reg_overdrive, 32'h0);
        apb(1'b0, PMRC_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_0004);
        apb(1'b1, PMRC_WKCFG_OFS, 32'hA5A5_0F0F);
        apb(1'b0, PMRC_WKCFG_OFS, 32'h0);
        chk(rd, 32'hA5A5_0F0F);
        apb(1'b0, 12'h010, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0004);
        repeat (3) @(posedge pclk);
        chk(reg_overdrive, 32'h1);
        apb(1'b1, PMRC_CTRL_OFS, 32'h0);
    endtask

    task automatic t_sleep();
        apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0001);
        wait_for(cpu_halt, 1'b1);
        chk({pll_en, core_power_en, reg_overdrive}, 32'h6);
        // A low clock enable must hold Sleep even with the interrupt up.
        clk_en <= 1'b0;
        periph_irq <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(cpu_halt, 32'h1);
        clk_en <= 1'b1;
        wait_for(cpu_halt, 1'b0);
        periph_irq <= 1'b0;
        apb(1'b0, PMRC_WKSRC_OFS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, PMRC_WKSRC_OFS, 32'h0000_000F);
    endtask

    // Every register choice in Stop, each left by a different event source.
    task automatic t_stop();
        logic [31:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 32'h0000_0002;
            c[CTRL_LPR_BIT] = k[0];
            c[CTRL_UDR_BIT] = k[1];
            apb(1'b1, PMRC_CTRL_OFS, c);
            wait_for(pll_en, 1'b0);
            chk({main_regulator_en, low_power_regulator_en}, 2 >> k[0]);
            chk(reg_underdrive, k[1]);
            chk({retain_contents, internal_fast_oscillator_en,
                 core_clk_gate}, 32'h5);
            {low_power_timer, usb_wakeup, rtc_event, voltage_detector_output,
                external_event_line} <= 23'h1 << src[k];
            wait_for(pll_en, 1'b1);
            {low_power_timer, usb_wakeup, rtc_event, voltage_detector_output,
                external_event_line} <= 23'h0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic t_bypass();
        bypass_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0004);
        repeat (4) @(posedge pclk);
        chk(reg_overdrive, 32'h0);
        apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0003);
        repeat (6) @(posedge pclk);
        chk({reg_powerdown, pll_en}, 32'h1);
        apb(1'b0, PMRC_WKSRC_OFS, 32'h0);
        chk(rd & 32'h8, 32'h8);
        apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0012);
        wait_for(pll_en, 1'b0);
        chk(reg_underdrive, 32'h0);
        external_event_line <= 16'h0008;
        wait_for(pll_en, 1'b1);
        external_event_line <= 16'h0000;
        core_domain_reset_pin <= 1'b0;
        repeat (5) @(posedge pclk);
        chk({core_part_reset_n, debug_por_allowed}, 32'h0);
        core_domain_reset_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(core_part_reset_n, 32'h1);
        bypass_pin <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // The pin reset goes last because it may clear more than the mode.
    task automatic t_standby();
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, PMRC_CTRL_OFS, 32'h0000_0023);
            wait_for(reg_powerdown, 1'b1);
            chk({core_power_en, retain_contents, pll_en}, 32'h0);
            chk(backup_sram_keep, 32'h1);
            case (k)
                0, 1: wakeup_pin[0] <= ~wakeup_pin[0];
                2: wakeup_pin[5] <= 1'b1;
                3: independent_watchdog <= 1'b1;
                4: rtc_event[1] <= 1'b1;
                default: external_reset_pin <= 1'b0;
            endcase
            wait_for(standby_reset_req, 1'b1);
            chk(pll_en, 32'h1);
            chk(reg_powerdown, 32'h0);
            independent_watchdog <= 1'b0;
            rtc_event <= 4'h0;
            external_reset_pin <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, bypass_pin, periph_irq} = 6'h00;
        {independent_watchdog, voltage_detector_output, usb_wakeup} = 3'h0;
        {low_power_timer, wakeup_pin, external_event_line, rtc_event} = 27'h0;
        {clk_en, core_domain_reset_pin, external_reset_pin} = 3'h7;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        total_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_run_regs();
        t_sleep();
        t_stop();
        t_bypass();
        t_standby();
        complete_run();
    end
endmodule
